//--- pkg/sspd_defs.svh
// constants for the store and stack-subtract decode block
// assumes inclusion by bare name from the package file; rtl files use the macros without including it
`ifndef SSPD_DEFS_SVH
`define SSPD_DEFS_SVH
`define SSPD_T1_HALFWORD_STORE_OP 7'h29
`define SSPD_T2_HALFWORD_STORE_HI 12'hF82
`define SSPD_T2_HALFWORD_STORE_ZERO 6'h00
`define SSPD_UNPRIV_HI 12'hF82
`define SSPD_UNPRIV_W_HI 12'hF84
`define SSPD_UNPRIV_MID 4'hE
`define SSPD_SUB_T1_OP 9'h161
`define SSPD_SP_REG 4'hD
`define SSPD_PC_REG 4'hF
`define SSPD_ALL_ONES 4'hF
`define SSPD_SIZE_HALF 3'h2
`define SSPD_SIZE_WORD 3'h4
`endif

//--- pkg/sspd_pkg.sv
// types shared by the store and stack-subtract decode block
// assumes sspd_defs.svh is on the include path
package sspd_pkg;
`include "sspd_defs.svh"

	typedef enum logic [5:0] {
		SSPD_OP_NONE = 6'h01,
		SSPD_OP_HALFWORD_STORE = 6'h02,
		SSPD_OP_UHALF = 6'h04,
		SSPD_OP_UWORD = 6'h08,
		SSPD_OP_SUB = 6'h10,
		SSPD_OP_CMP = 6'h20
	} sspd_op_e;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [31:0] data;
		logic [2:0] size;
		logic unpriv;
	} sspd_store_s;

	typedef struct packed {
		logic valid;
		logic [3:0] dest;
		logic [31:0] value;
		logic limit_check;
	} sspd_regwr_s;

	typedef struct packed {
		logic valid;
		logic n;
		logic z;
		logic c;
		logic v;
	} sspd_flags_s;

	typedef struct packed {
		sspd_store_s store;
		sspd_regwr_s regwr;
		sspd_flags_s flags;
		logic undefined;
		logic unpredictable;
		logic is_cmp;
		logic fault_capable;
		logic done;
	} sspd_state_s;
endpackage : sspd_pkg

//--- rtl/sspd_expand_imm.sv
// modified-immediate expansion of the 12-bit i:middle_immediate_field:byte_immediate_field constant
// assumes purely combinational use, carry-out not needed here
`timescale 1ns/1ps
module sspd_expand_imm (
	input wire logic [11:0] imm12_in,
	output logic [31:0] value_out
);
	logic [7:0] lo;
	logic [31:0] unrot;
	logic [4:0] rot;

	always_comb begin
		lo = imm12_in[7:0];
		rot = imm12_in[11:7];
		unrot = {24'h000000, 1'b1, imm12_in[6:0]};
		value_out = 32'h00000000;
		if (imm12_in[11:10] == 2'h0) begin
			unique case (imm12_in[9:8])
				2'h0: value_out = {24'h000000, lo};
				2'h1: value_out = {8'h00, lo, 8'h00, lo};
				2'h2: value_out = {lo, 8'h00, lo, 8'h00};
				2'h3: value_out = {lo, lo, lo, lo};
			endcase
		end else begin
			value_out = (unrot >> rot) | (unrot << (6'h20 - {1'b0, rot}));
		end
	end
endmodule : sspd_expand_imm

//--- rtl/sspd_decode.sv
// decode and execute for halfword/word stores and stack subtract
// assumes register values are read by the pipeline and given with the instruction
// How it works
// - short halfword store: index unshifted, no writeback
// - wide halfword store shifts index by two-bit field
// - base all ones makes wide stores undefined
// - without main extension wide encodings are undefined
// - wide halfword store, transfer/index 13 or 15 unpredictable
// - halfword store writes low 16 bits, two bytes
// - unprivileged halfword store is two-byte low-half write
// - unprivileged stores add zero-extended byte immediate
// - unprivileged store transfer 13 or 15 unpredictable
// - unprivileged word store writes whole register, four bytes
// - unprivileged stores may raise any memory fault
// - short stack subtract: SP, no flags, word_scaled_immediate_field times four
// - wide subtract, dest ones and S set is compare
// - wide subtract sets flags only on S, expanded immediate
// - wide subtract, dest 15 with S clear unpredictable
// - T3 subtract zero-extends twelve-bit immediate, no flags
// - T3 subtract with dest 15 unpredictable
// - subtract via inverted add, limit check, flags NZCV
`timescale 1ns/1ps
module sspd_decode
	import sspd_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic instr_valid_in,
	input wire logic instr_wide_in,
	input wire logic [31:0] instr_in,
	input wire logic cond_pass_in,
	input wire logic main_ext_in,
	input wire logic [31:0] base_value_in,
	input wire logic [31:0] index_value_in,
	input wire logic [31:0] transfer_value_in,
	input wire logic [31:0] sp_value_in,
	output logic store_valid_out,
	output logic [31:0] store_addr_out,
	output logic [31:0] store_data_out,
	output logic [2:0] store_size_out,
	output logic store_unpriv_out,
	output logic reg_write_out,
	output logic [3:0] reg_dest_out,
	output logic [31:0] reg_value_out,
	output logic reg_limit_check_out,
	output logic flags_write_out,
	output logic [3:0] flags_nzcv_out,
	output logic undefined_out,
	output logic unpredictable_out,
	output logic compare_redirect_out,
	output logic fault_capable_out,
	output logic done_out,
	output logic [5:0] op_out
);
	sspd_state_s state;
	sspd_state_s next_state;
	sspd_op_e op;
	sspd_op_e next_op;
	logic [31:0] expanded;
	logic [31:0] imm32;
	logic [32:0] sum;
	logic [31:0] result;
	logic [11:0] imm12;
	logic [3:0] rt;
	logic [3:0] rn;
	logic [3:0] rm;
	logic [3:0] rd;
	logic [1:0] shamt;
	logic setflags;
	logic sub_t3;
	logic wide;

	function automatic logic is_sp_or_pc(input logic [3:0] r);
		is_sp_or_pc = (r == `SSPD_SP_REG) || (r == `SSPD_PC_REG);
	endfunction : is_sp_or_pc

	function automatic logic [31:0] zext8(input logic [7:0] b);
		zext8 = {24'h000000, b};
	endfunction : zext8

	assign imm12 = {instr_in[26], instr_in[14:12], instr_in[7:0]};

	sspd_expand_imm u_expand (
		.imm12_in(imm12),
		.value_out(expanded)
	);

	always_comb begin
		next_state = '0;
		next_op = SSPD_OP_NONE;
		imm32 = 32'h00000000;
		sum = 33'h000000000;
		result = 32'h00000000;
		setflags = 1'b0;
		sub_t3 = 1'b0;
		wide = instr_wide_in;
		rt = instr_in[15:12];
		rn = instr_in[19:16];
		rm = instr_in[3:0];
		rd = instr_in[11:8];
		shamt = instr_in[5:4];
		if (instr_valid_in) begin
			next_state.done = 1'b1;
			if (!wide && instr_in[15:9] == `SSPD_T1_HALFWORD_STORE_OP) begin
				next_op = SSPD_OP_HALFWORD_STORE;
				rt = {1'b0, instr_in[2:0]};
				rn = {1'b0, instr_in[5:3]};
				rm = {1'b0, instr_in[8:6]};
				next_state.store.addr = base_value_in + index_value_in;
			end else if (!wide && instr_in[15:7] == `SSPD_SUB_T1_OP) begin
				next_op = SSPD_OP_SUB;
				rd = `SSPD_SP_REG;
				imm32 = {23'h000000, instr_in[6:0], 2'h0};
			end else if (wide && instr_in[31:20] == `SSPD_T2_HALFWORD_STORE_HI && instr_in[11:6] == `SSPD_T2_HALFWORD_STORE_ZERO) begin
				next_op = SSPD_OP_HALFWORD_STORE;
				next_state.store.addr = base_value_in + (index_value_in << shamt);
				next_state.unpredictable = is_sp_or_pc(rt) || is_sp_or_pc(rm);
				next_state.undefined = (rn == `SSPD_ALL_ONES);
			end else if (wide && (instr_in[31:20] == `SSPD_UNPRIV_HI || instr_in[31:20] == `SSPD_UNPRIV_W_HI)
				&& instr_in[11:8] == `SSPD_UNPRIV_MID) begin
				next_op = (instr_in[22]) ? SSPD_OP_UWORD : SSPD_OP_UHALF;
				next_state.store.addr = base_value_in + zext8(instr_in[7:0]);
				next_state.unpredictable = is_sp_or_pc(rt);
				next_state.undefined = (rn == `SSPD_ALL_ONES);
			end else if (wide && instr_in[31:27] == 5'h1E && instr_in[15] == 1'b0 && instr_in[19:16] == `SSPD_SP_REG
				&& (instr_in[25:21] == 5'h0D || instr_in[25:20] == 6'h2A)) begin
				sub_t3 = (instr_in[25:20] == 6'h2A);
				if (sub_t3) begin
					next_op = SSPD_OP_SUB;
					imm32 = {20'h00000, imm12};
					next_state.unpredictable = (rd == `SSPD_PC_REG);
				end else if (rd == `SSPD_ALL_ONES && instr_in[20]) begin
					next_op = SSPD_OP_CMP;
					next_state.is_cmp = 1'b1;
				end else begin
					next_op = SSPD_OP_SUB;
					setflags = instr_in[20];
					imm32 = expanded;
					next_state.unpredictable = (rd == `SSPD_PC_REG) && !instr_in[20];
				end
			end else begin
				next_state.done = 1'b0;
			end
			// wide encodings vanish without the main extension; short ones stay
			if (wide && next_op != SSPD_OP_NONE && !main_ext_in) begin
				next_state.undefined = 1'b1;
				next_state.is_cmp = 1'b0;
			end
			sum = {1'b0, sp_value_in} + {1'b0, ~imm32} + 33'h000000001;
			result = sum[31:0];
			if (cond_pass_in && !next_state.undefined && !next_state.is_cmp) begin
				unique case (next_op)
					SSPD_OP_HALFWORD_STORE, SSPD_OP_UHALF: begin
						next_state.store.valid = 1'b1;
						next_state.store.data = {16'h0000, transfer_value_in[15:0]};
						next_state.store.size = `SSPD_SIZE_HALF;
						next_state.store.unpriv = (next_op == SSPD_OP_UHALF);
						next_state.fault_capable = (next_op == SSPD_OP_UHALF);
					end
					SSPD_OP_UWORD: begin
						next_state.store.valid = 1'b1;
						next_state.store.data = transfer_value_in;
						next_state.store.size = `SSPD_SIZE_WORD;
						next_state.store.unpriv = 1'b1;
						next_state.fault_capable = 1'b1;
					end
					SSPD_OP_SUB: begin
						next_state.regwr.valid = 1'b1;
						next_state.regwr.dest = rd;
						next_state.regwr.value = result;
						next_state.regwr.limit_check = 1'b1;
						next_state.flags.valid = setflags;
						next_state.flags.n = result[31];
						next_state.flags.z = (result == 32'h00000000);
						next_state.flags.c = sum[32];
						next_state.flags.v = (sp_value_in[31] == ~imm32[31]) && (result[31] != sp_value_in[31]);
					end
					default: begin
						next_state.store.valid = 1'b0;
					end
				endcase
			end
			if (next_state.store.valid == 1'b0) begin
				next_state.store.addr = 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state <= '0;
			op <= SSPD_OP_NONE;
		end else begin
			state <= next_state;
			op <= next_op;
		end
	end

	assign store_valid_out = state.store.valid;
	assign store_addr_out = state.store.addr;
	assign store_data_out = state.store.data;
	assign store_size_out = state.store.size;
	assign store_unpriv_out = state.store.unpriv;
	assign reg_write_out = state.regwr.valid;
	assign reg_dest_out = state.regwr.dest;
	assign reg_value_out = state.regwr.value;
	assign reg_limit_check_out = state.regwr.limit_check;
	assign flags_write_out = state.flags.valid;
	assign flags_nzcv_out = {state.flags.n, state.flags.z, state.flags.c, state.flags.v};
	assign undefined_out = state.undefined;
	assign unpredictable_out = state.unpredictable;
	assign compare_redirect_out = state.is_cmp;
	assign fault_capable_out = state.fault_capable;
	assign done_out = state.done;
	assign op_out = op;
endmodule : sspd_decode

//--- bench/sspd_mem_model.sv
// far-side store sink: counts store requests and keeps the last data
// assumes one-cycle request pulses sampled on the rising clock edge
`timescale 1ns/1ps
module sspd_mem_model (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic store_valid_in,
	input wire logic [31:0] store_data_in,
	output logic [31:0] last_data_out,
	output logic [7:0] count_out
);
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			count_out <= 8'h00;
			last_data_out <= 32'h0;
		end else if (store_valid_in) begin
			count_out <= count_out + 8'h01;
			last_data_out <= store_data_in;
		end
	end
endmodule : sspd_mem_model

//--- bench/sspd_decode_assertions.sv
// port-level checks for the store and stack-subtract decode block
// assumes one clock domain and results one cycle after the instruction edge
`timescale 1ns/1ps
module sspd_decode_assertions (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic instr_valid_in,
	input wire logic instr_wide_in,
	input wire logic [31:0] instr_in,
	input wire logic cond_pass_in,
	input wire logic main_ext_in,
	input wire logic [31:0] base_value_in,
	input wire logic [31:0] index_value_in,
	input wire logic [31:0] sp_value_in,
	input wire logic store_valid_out,
	input wire logic [31:0] store_addr_out,
	input wire logic [2:0] store_size_out,
	input wire logic store_unpriv_out,
	input wire logic reg_write_out,
	input wire logic [3:0] reg_dest_out,
	input wire logic [31:0] reg_value_out,
	input wire logic flags_write_out,
	input wire logic undefined_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);
	logic sh;
	logic wd;
	logic [11:0] hi;
	assign sh = instr_valid_in && !instr_wide_in && cond_pass_in;
	assign wd = instr_valid_in && instr_wide_in && cond_pass_in && main_ext_in;
	assign hi = instr_in[31:20];
	sequence s_quiet;
		!store_valid_out && !reg_write_out && !flags_write_out;
	endsequence
	a_short_halfword_store: assert property (
		sh && instr_in[15:9] == 7'h29 |=> store_valid_out && store_size_out == 3'h2
		&& store_addr_out == $past(base_value_in) + $past(index_value_in)) else $error("short store wrong");
	a_wide_shift: assert property (
		wd && hi == 12'hF82 && instr_in[19:16] != 4'hF && instr_in[11:6] == 6'h00
		|=> store_addr_out == $past(base_value_in) + ($past(index_value_in) << $past(instr_in[5:4])))
		else $error("wide store address wrong");
	a_base_undef: assert property (
		instr_valid_in && instr_wide_in && hi inside {12'hF82, 12'hF84} && instr_in[19:16] == 4'hF
		&& instr_in[11:8] == 4'hE |=> undefined_out && !store_valid_out) else $error("base ones not undefined");
	a_noext_undef: assert property (
		instr_valid_in && instr_wide_in && !main_ext_in && hi == 12'hF84 && instr_in[11:8] == 4'hE
		|=> undefined_out && !store_valid_out) else $error("wide form without extension not undefined");
	a_uword_store: assert property (
		wd && hi == 12'hF84 && instr_in[19:16] != 4'hF && instr_in[11:8] == 4'hE |=> store_unpriv_out
		&& store_size_out == 3'h4 && store_addr_out == $past(base_value_in) + $past(instr_in[7:0]))
		else $error("unprivileged word store wrong");
	a_sub_short: assert property (
		sh && instr_in[15:7] == 9'h161 |=> reg_write_out && reg_dest_out == 4'hD && !flags_write_out
		&& reg_value_out == $past(sp_value_in) - {$past(instr_in[6:0]), 2'h0}) else $error("short sp subtract wrong");
	a_t2_noflags: assert property (
		wd && instr_in[31:27] == 5'h1E && instr_in[25:16] == 10'h1AD |=> !flags_write_out)
		else $error("flags written without set bit");
	a_t3_sub: assert property (
		wd && instr_in[31:27] == 5'h1E && instr_in[25:16] == 10'h2AD && !instr_in[15] |=> !flags_write_out
		&& reg_value_out == $past(sp_value_in) - {$past(instr_in[26]), $past(instr_in[14:12]), $past(instr_in[7:0])})
		else $error("wide sp subtract wrong");
	a_cond_quiet: assert property (
		instr_valid_in && !cond_pass_in |=> s_quiet) else $error("effects after failed condition");
endmodule : sspd_decode_assertions
bind sspd_decode sspd_decode_assertions u_chk (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
	.instr_valid_in(instr_valid_in), .instr_wide_in(instr_wide_in), .instr_in(instr_in), .cond_pass_in(cond_pass_in),
	.main_ext_in(main_ext_in), .base_value_in(base_value_in), .index_value_in(index_value_in),
	.sp_value_in(sp_value_in), .store_valid_out(store_valid_out), .store_addr_out(store_addr_out),
	.store_size_out(store_size_out), .store_unpriv_out(store_unpriv_out), .reg_write_out(reg_write_out),
	.reg_dest_out(reg_dest_out), .reg_value_out(reg_value_out), .flags_write_out(flags_write_out),
	.undefined_out(undefined_out));

//--- bench/testbench.sv
// self-checking bench for the store and stack-subtract decode block
// assumes inputs change on the falling edge and results appear one cycle later
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst = 1, v = 0, w = 0, cp = 1, me = 1, sv, su, rw, fw, und, unp, cmp, fc, dn, lc;
	logic [31:0] ins = 0, bv = 32'h1000, iv = 32'h6, tv = 32'hABCD1234, sp = 32'h2000, sa, sd, rv, md;
	logic [2:0] ss;
	logic [3:0] rd, fl;
	logic [7:0] cnt;
	logic [5:0] op;
	int miscompares = 0, num_checks = 0;
	always #2.5 clk = ~clk;
	sspd_decode DUT (.clk_sys_in(clk), .sys_rst_in(rst), .instr_valid_in(v), .instr_wide_in(w), .instr_in(ins),
		.cond_pass_in(cp), .main_ext_in(me), .base_value_in(bv), .index_value_in(iv), .transfer_value_in(tv),
		.sp_value_in(sp), .store_valid_out(sv), .store_addr_out(sa), .store_data_out(sd), .store_size_out(ss),
		.store_unpriv_out(su), .reg_write_out(rw), .reg_dest_out(rd), .reg_value_out(rv), .reg_limit_check_out(lc),
		.flags_write_out(fw), .flags_nzcv_out(fl), .undefined_out(und), .unpredictable_out(unp),
		.compare_redirect_out(cmp), .fault_capable_out(fc), .done_out(dn), .op_out(op));
	sspd_mem_model MEM (.clk_sys_in(clk), .sys_rst_in(rst), .store_valid_in(sv), .store_data_in(sd),
		.last_data_out(md), .count_out(cnt));
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// holds valid across calls so back-to-back instructions never toggle it
	task run(input logic wd, input logic [31:0] i);
		v = 1;
		w = wd;
		ins = i;
		@(negedge clk);
	endtask : run
	initial begin
		repeat (6) @(negedge clk);
		chk("rst_state", 32'h00000001, {dn, sv, rw, fw, und, op});
		rst = 0;
		run(0, 32'h5288);
		chk("addr", bv + iv, sa);
		chk("done_op", 7'h42, {dn, op});
		chk("data", {16'h0, tv[15:0]}, sd);
		chk("size", 3'h2, ss);
		for (int k = 0; k < 4; k++) begin
			run(1, {12'hF82, 4'h1, 4'h2, 6'h00, k[1:0], 4'h3});
			chk("shift_addr", bv + (iv << k), sa);
		end
		run(1, 32'hF8212EFF);
		chk("uh_addr", bv + 32'hFF, sa);
		chk("uh_size_priv", 4'h5, {ss, su});
		run(1, 32'hF8412E10);
		chk("uw_data", tv, sd);
		chk("uw_fault", 4'h9, {ss, fc});
		chk("uw_unpriv", 2'h3, {su, sv});
		chk("uw_addr", bv + 32'h10, sa);
		run(1, 32'hF84F2E10);
		chk("base_ones", 2'h2, {und, sv});
		run(1, 32'hF841DE10);
		chk("unpred_t", 2'h3, {unp, sv});
		run(1, 32'hF821200F);
		chk("unpred_m", 1'h1, unp);
		me = 0;
		run(1, 32'hF8412E10);
		chk("no_ext", 2'h2, {und, sv});
		run(0, 32'h5288);
		chk("no_ext_short", 1'h1, sv);
		me = 1;
		run(0, 32'hB0FF);
		chk("sp_t1", sp - 32'h1FC, rv);
		chk("sp_t1_dest", 5'h0D, {fw, rd});
		chk("sp_t1_limit", 2'h3, {rw, lc});
		run(1, 32'hF6AD73FF);
		chk("sp_t3", {sp - 32'hFFF}, rv);
		chk("sp_t3_fl", 1'h0, fw);
		run(1, 32'hF1BD1201);
		chk("sp_t2", sp - 32'h10001, rv);
		chk("sp_t2_fl", 5'h18, {fw, fl});
		run(1, 32'hF1AD1201);
		chk("sp_t2_ns", 1'h0, fw);
		run(1, 32'hF1BD0F01);
		chk("cmp", 2'h2, {cmp, rw});
		run(1, 32'hF1AD0F01);
		chk("t2_pc", 1'h1, unp);
		run(1, 32'hF2AD0F01);
		chk("t3_pc", 1'h1, unp);
		cp = 0;
		run(1, 32'hF8412E10);
		chk("cond_fail", 3'h0, {sv, rw, fw});
		cp = 1;
		run(0, 32'h0000);
		chk("unknown", 32'h00000001, {dn, sv, rw, fw, und, op});
		v = 0;
		cp = 1;
		repeat (2) @(negedge clk);
		chk("stores", 8'h0A, cnt);
		chk("last_data", {16'h0, tv[15:0]}, md);
		final_report;
	end
	// about 30 cycles of tests; this margin only trips on a hang
	initial begin
		#10000;
		miscompares++;
		final_report;
	end
endmodule : testbench
